// *** hdl/lpc_clock_ctrl.sv ***
// Summary of operation
// R01: subactive runs on sub clock, tone off
// R02: subactive cycle set by sub divider bit
// R03: software changes sub divider only when active; sel1 writes are taken in any mode
// R04: stop/standby in subactive picks watch or active
// R05: frame strobe from sub time base, length selectable
// R06: slow-mode interrupts issued on frame strobe
// R07: wake edge counts at second strobe after
// R08: wake levels must exceed one frame
// R09: direct transfer: clear low speed, set direct
// R10: direct flag set only subactive, cleared active
// R11: direct transition exceeds settle, below frame+settle
// R12: stop release enters active, fetch from zero
// R13: ram valid zero after reset, one after release
// R14: reset cancels all, release input only in stop
// R15: asynchronous reset pin resets in any mode
// R16: stop/standby becomes nop with pending unmasked flag
// R17: halt bit stops 32k oscillator in stop
// R18: sub clock divide by eight or four
// R19: frequency bits must match fitted oscillator
// R20: divider bits pick quarter to thirty-second
// R21: divider takes effect on entering watch
// R22: strap pin sets divider after reset/release
// R23: watch wake goes active or subactive by flag
// R24: five-state mode machine, reset forces active
//
// Implementation choice: strobed register access.
`include "lpc_defs.svh"
module lpc_clock_ctrl #(
	parameter int unsigned SETTLE_CYC = `LPC_SETTLE_CYC
) (
	// clock and reset
	input  wire logic       MCLK_I,
	input  wire logic       RST_I,
	// device pins, asynchronous
	input  wire logic       RESET_PIN_N_I,
	input  wire logic       HALT_RELEASE_N_I,
	input  wire logic       WAKE_N_I,
	input  wire logic       DIV_STRAP_I,
	input  wire logic       SUB_CLK_I,
	// core side
	input  wire logic       STOP_INSTR_I,
	input  wire logic       STANDBY_INSTR_I,
	input  wire logic       WATCH_ON_STOP_I,
	input  wire logic       GIE_I,
	input  wire logic       IRQ_PEND_I,
	input  wire logic       TIMERA_OVF_I,
	// register port
	input  wire logic [5:0] ADDR_I,
	input  wire logic [3:0] WDATA_I,
	input  wire logic       WR_I,
	input  wire logic       RD_I,
	output logic      [3:0] RDATA_O,
	// mode and clock controls
	output logic      [4:0] MODE_O,
	output logic            MAIN_OSC_EN_O,
	output logic            SUB_OSC_EN_O,
	output logic            CPU_RUN_O,
	output logic            TONE_EN_O,
	output logic      [1:0] CORE_DIV_O,
	output logic      [3:0] MAIN_FREQ_O,
	output logic            SUB_DIV4_O,
	// events
	output logic            FRAME_STROBE_O,
	output logic            TIMERA_IRQ_O,
	output logic            WAKE_IRQ_O,
	output logic            FETCH_ZERO_O,
	output logic            INSTR_NOP_O,
	output logic            RAM_VALID_O
);
	localparam int SW = $clog2(SETTLE_CYC + 1);
	localparam logic [SW-1:0] SETTLE_END = SW'(SETTLE_CYC);

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic [4:0] pin_raw;   // sub clk, strap, wake, halt, reset
	logic [4:0] pin_s1;    // first stage, read by s2 only
	logic [4:0] pin_s2;    // safe to use
	logic [4:0] pin_s3;    // edge history
	localparam logic [4:0] PIN_RST = 5'h0F;
	assign pin_raw = {SUB_CLK_I, DIV_STRAP_I, WAKE_N_I,
		HALT_RELEASE_N_I, RESET_PIN_N_I};

	// one chain per pin
	genvar gi;
	generate
		for (gi = 0; gi < 5; gi++) begin : g_sync
			always_ff @(posedge MCLK_I) begin
				if (RST_I) begin
					pin_s1[gi] <= PIN_RST[gi];
					pin_s2[gi] <= PIN_RST[gi];
					pin_s3[gi] <= PIN_RST[gi];
				end else begin
					pin_s1[gi] <= pin_raw[gi];
					pin_s2[gi] <= pin_s1[gi];
					pin_s3[gi] <= pin_s2[gi];
				end
			end
		end
	endgenerate

	// R15: pin reset joins the system reset
	wire hard_rst  = RST_I | ~pin_s2[0];
	wire halt_low  = ~pin_s2[1];
	wire wake_fall = ~pin_s2[2] & pin_s3[2];
	wire strap_hi  = pin_s2[3];
	wire sub_tick  = pin_s2[4] & ~pin_s3[4];

	// ----------------------------------------
	// state
	// ----------------------------------------
	lpc_pkg::lpc_mode_t mode;       // current mode
	lpc_pkg::lpc_mode_t next_mode;
	logic          low_speed;       // mode flag bit 0
	logic          direct;          // mode flag bit 3
	logic    [1:0] frame_sel;       // frame length select
	logic    [3:0] sel1;            // first clock select
	logic    [1:0] freq_ab;         // frequency bits, second reg
	logic    [1:0] div_pend;        // written divider
	logic    [1:0] div_eff;         // divider in use
	logic          ram_valid;
	logic    [1:0] strap_cnt;       // strap reload window
	logic    [9:0] frame_cnt;       // sub ticks in frame
	logic          settling;        // oscillator settle running
	logic [SW-1:0] settle_cnt;
	logic          dt_wait;         // direct move waits strobe
	logic          ta_pend;         // timer A overflow held
	logic    [1:0] wk_cnt;          // strobes left for wake
	logic          go_settle;
	logic          div_apply;
	logic          stop_release;
	logic          nop_pulse;
	logic          enter_dt;

	// ----------------------------------------
	// decodes
	// ----------------------------------------
	wire in_act   = (mode == lpc_pkg::LPC_ACTIVE);
	wire in_watch = (mode == lpc_pkg::LPC_WATCH);
	wire in_stop  = (mode == lpc_pkg::LPC_STOP);
	wire in_sub   = (mode == lpc_pkg::LPC_SUBACT);
	wire instr    = STOP_INSTR_I | STANDBY_INSTR_I;
	// R16: pending unmasked flag with interrupts off
	wire nop_cond = ~GIE_I & IRQ_PEND_I;
	wire wr_frame = WR_I & (ADDR_I == `LPC_ADR_FRAME);
	wire wr_mode  = WR_I & (ADDR_I == `LPC_ADR_MODE);
	wire wr_sel1  = WR_I & (ADDR_I == `LPC_ADR_SEL1);
	wire wr_sel2  = WR_I & (ADDR_I == `LPC_ADR_SEL2);
	wire settle_done = settling & (settle_cnt == SETTLE_END);
	wire [1:0] strap_div = strap_hi ? `LPC_DIV_4 : `LPC_DIV_32;

	// ----------------------------------------
	// interrupt frame time base
	// ----------------------------------------
	// R05: three lengths, code 3 reuses the longest
	wire [9:0] frame_len = (frame_sel == 2'h0) ? `LPC_FRAME_T0 :
		(frame_sel == 2'h1) ? `LPC_FRAME_T1 : `LPC_FRAME_T2;
	wire frame_end = sub_tick & (frame_cnt == frame_len - 10'h001);
	// R06: align only in slow modes outside the active move
	wire aligned = (in_watch | in_sub) & ~settling;

	// R06: timer A request released on the strobe
	wire ta_fire = ta_pend & (~aligned | frame_end);
	// R07: second strobe after the wake edge
	wire wk_fire = (wake_fall & ~aligned) |
		((wk_cnt != 2'h0) & (~aligned | (frame_end & wk_cnt == 2'h1)));
	wire wake_evt = ta_fire | wk_fire;

	// ----------------------------------------
	// mode machine
	// ----------------------------------------
	// R24: defaults hold the mode
	always_comb begin
		next_mode    = mode;
		go_settle    = 1'b0;
		div_apply    = 1'b0;
		stop_release = 1'b0;
		nop_pulse    = 1'b0;
		enter_dt     = 1'b0;
		case (mode)
			lpc_pkg::LPC_ACTIVE: begin
				// R16: cancelled instruction
				if (instr & nop_cond) begin
					nop_pulse = 1'b1;
				end else if (STOP_INSTR_I) begin
					next_mode = WATCH_ON_STOP_I ? lpc_pkg::LPC_WATCH : lpc_pkg::LPC_STOP;
					// R21: new divider on watch entry
					div_apply = WATCH_ON_STOP_I;
				end else if (STANDBY_INSTR_I) begin
					next_mode = lpc_pkg::LPC_STANDBY;
				end
			end
			lpc_pkg::LPC_STANDBY: begin
				// any interrupt request resumes
				if (IRQ_PEND_I) begin
					next_mode = lpc_pkg::LPC_ACTIVE;
				end
			end
			lpc_pkg::LPC_WATCH: begin
				// R23: wake target by low speed flag
				if (settle_done) begin
					next_mode = lpc_pkg::LPC_ACTIVE;
				end else if (wake_evt & ~settling) begin
					if (low_speed) begin
						next_mode = lpc_pkg::LPC_SUBACT;
					end else begin
						go_settle = 1'b1;
					end
				end
			end
			lpc_pkg::LPC_STOP: begin
				// R14: release input acts only here
				if (settle_done) begin
					// R12: active from address zero
					next_mode    = lpc_pkg::LPC_ACTIVE;
					stop_release = 1'b1;
				end else if (halt_low & ~settling) begin
					go_settle = 1'b1;
				end
			end
			lpc_pkg::LPC_SUBACT: begin
				if (settle_done) begin
					next_mode = lpc_pkg::LPC_ACTIVE;
				end else if (dt_wait) begin
					// R11: wait strobe, then full settle
					go_settle = frame_end;
				end else if (settling) begin
					next_mode = mode;
				end else if (instr & nop_cond) begin
					nop_pulse = 1'b1;
				end else if (instr) begin
					// R04: direct only with low speed clear
					// R09: direct move when direct is set and low speed is clear
					div_apply = 1'b1;
					if (direct & ~low_speed) begin
						enter_dt = 1'b1;
					end else begin
						next_mode = lpc_pkg::LPC_WATCH;
					end
				end
			end
			default: begin
				next_mode = lpc_pkg::LPC_ACTIVE;
			end
		endcase
	end

	// R24: mode register, reset forces active
	always_ff @(posedge MCLK_I) begin
		if (hard_rst) begin
			mode <= lpc_pkg::LPC_ACTIVE;
		end else begin
			mode <= next_mode;
		end
	end

	// R11: settle counter, one cycle beyond the figure
	always_ff @(posedge MCLK_I) begin
		if (hard_rst | settle_done) begin
			settling   <= 1'b0;
			settle_cnt <= '0;
		end else if (go_settle) begin
			settling   <= 1'b1;
			settle_cnt <= '0;
		end else if (settling) begin
			settle_cnt <= settle_cnt + SW'(1);
		end
	end

	// direct move waiting for the frame strobe
	always_ff @(posedge MCLK_I) begin
		if (hard_rst | go_settle) begin
			dt_wait <= 1'b0;
		end else if (enter_dt) begin
			dt_wait <= 1'b1;
		end
	end

	// frame counter runs in every mode
	always_ff @(posedge MCLK_I) begin
		if (hard_rst | frame_end) begin
			frame_cnt <= 10'h000;
		end else if (sub_tick) begin
			frame_cnt <= frame_cnt + 10'h001;
		end
	end

	// event holders, a new event beats the release
	always_ff @(posedge MCLK_I) begin
		if (hard_rst) begin
			ta_pend <= 1'b0;
			wk_cnt  <= 2'h0;
		end else begin
			ta_pend <= TIMERA_OVF_I | (ta_pend & ~ta_fire);
			if (wake_fall & aligned) begin
				wk_cnt <= 2'h2;
			end else if (wk_fire) begin
				wk_cnt <= 2'h0;
			end else if (frame_end & wk_cnt != 2'h0) begin
				wk_cnt <= wk_cnt - 2'h1;
			end
		end
	end

	// ----------------------------------------
	// software registers
	// ----------------------------------------
	// plain flags and selects
	always_ff @(posedge MCLK_I) begin
		if (hard_rst) begin
			low_speed <= 1'b0;
			frame_sel <= `LPC_RST_FRAME;
			sel1      <= `LPC_RST_SEL1;
			freq_ab   <= `LPC_RST_FREQ;
		end else begin
			if (wr_mode) begin
				low_speed <= WDATA_I[`LPC_BIT_LOWSPD];
			end
			if (wr_frame) begin
				frame_sel <= WDATA_I[1:0];
			end
			// R18: sub divider acts at once
			// R19: frequency code passed out unchanged
			if (wr_sel1) begin
				sel1 <= WDATA_I;
			end
			if (wr_sel2) begin
				freq_ab <= WDATA_I[3:2];
			end
		end
	end

	// R10: direct flag held clear while active
	always_ff @(posedge MCLK_I) begin
		if (hard_rst | in_act) begin
			direct <= 1'b0;
		end else if (wr_mode & in_sub) begin
			direct <= WDATA_I[`LPC_BIT_DIRECT];
		end
	end

	// R22: strap reload after reset and release
	always_ff @(posedge MCLK_I) begin
		if (hard_rst | stop_release) begin
			strap_cnt <= `LPC_STRAP_CYC;
		end else if (strap_cnt != 2'h0) begin
			strap_cnt <= strap_cnt - 2'h1;
		end
	end

	// R20: divider code, R21: applied on watch entry or direct move
	always_ff @(posedge MCLK_I) begin
		if (hard_rst) begin
			div_pend <= `LPC_DIV_4;
			div_eff  <= `LPC_DIV_4;
		end else if (strap_cnt != 2'h0) begin
			div_pend <= strap_div;
			div_eff  <= strap_div;
		end else begin
			if (wr_sel2) begin
				div_pend <= WDATA_I[1:0];
			end
			if (div_apply) begin
				div_eff <= div_pend;
			end
		end
	end

	// R13: ram valid tells release from reset
	always_ff @(posedge MCLK_I) begin
		if (hard_rst) begin
			ram_valid <= 1'b0;
		end else if (stop_release) begin
			ram_valid <= 1'b1;
		end
	end

	// read mux, first select register reads zero
	wire [3:0] rd_mux =
		(ADDR_I == `LPC_ADR_FRAME) ? {2'h0, frame_sel} :
		(ADDR_I == `LPC_ADR_MODE)  ? {direct, 2'h0, low_speed} :
		(ADDR_I == `LPC_ADR_RAM)   ? {ram_valid, 3'h0} :
		(ADDR_I == `LPC_ADR_SEL2)  ? {freq_ab, div_pend} : 4'h0;

	// ----------------------------------------
	// output flops
	// ----------------------------------------
	// R01: tone only in active and standby
	// R17: 32k oscillator may halt in stop
	always_ff @(posedge MCLK_I) begin
		if (hard_rst) begin
			RDATA_O        <= 4'h0;
			MAIN_OSC_EN_O  <= 1'b1;
			SUB_OSC_EN_O   <= 1'b1;
			CPU_RUN_O      <= 1'b1;
			TONE_EN_O      <= 1'b1;
			FRAME_STROBE_O <= 1'b0;
			TIMERA_IRQ_O   <= 1'b0;
			WAKE_IRQ_O     <= 1'b0;
			FETCH_ZERO_O   <= 1'b0;
			INSTR_NOP_O    <= 1'b0;
		end else begin
			RDATA_O        <= RD_I ? rd_mux : 4'h0;
			MAIN_OSC_EN_O  <= in_act | (mode == lpc_pkg::LPC_STANDBY) | settling;
			SUB_OSC_EN_O   <= ~(in_stop & sel1[`LPC_BIT_HALT32]);
			CPU_RUN_O      <= in_act | (in_sub & ~dt_wait & ~settling);
			TONE_EN_O      <= in_act | (mode == lpc_pkg::LPC_STANDBY);
			FRAME_STROBE_O <= frame_end;
			TIMERA_IRQ_O   <= ta_fire;
			WAKE_IRQ_O     <= wk_fire;
			// one-cycle pulse: the strap reload that follows a release must not stretch it
			FETCH_ZERO_O   <= stop_release | ((strap_cnt == `LPC_STRAP_CYC) & ~FETCH_ZERO_O);
			INSTR_NOP_O    <= nop_pulse;
		end
	end

	// R02: sub divider bit sets subactive cycle
	assign SUB_DIV4_O  = sel1[`LPC_BIT_SUBDIV];
	assign MODE_O      = mode;
	assign CORE_DIV_O  = div_eff;
	assign MAIN_FREQ_O = {freq_ab, sel1[1:0]};
	assign RAM_VALID_O = ram_valid;

	// divider may move only on these two causes
	wire div_load = div_apply | (strap_cnt != 2'h0);

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge MCLK_I); endclocking
	default disable iff (hard_rst);

	property p_tone; in_sub |=> !TONE_EN_O; endproperty
	a_tone: assert property (p_tone) else $error("tone on in subactive"); // R01
	property p_subdiv; wr_sel1 |=> SUB_DIV4_O == $past(WDATA_I[2]); endproperty
	a_subdiv: assert property (p_subdiv) else $error("sub divider late"); // R18
	property p_towatch;
		in_sub & instr & !nop_cond & !dt_wait & !settling & (low_speed | !direct)
		|=> mode == lpc_pkg::LPC_WATCH;
	endproperty
	a_towatch: assert property (p_towatch) else $error("subactive exit wrong"); // R04
	property p_frame; FRAME_STROBE_O |=> !FRAME_STROBE_O [*7]; endproperty
	a_frame: assert property (p_frame) else $error("frame too short"); // R05
	property p_align; $past(aligned) & TIMERA_IRQ_O |-> FRAME_STROBE_O; endproperty
	a_align: assert property (p_align) else $error("timer irq off strobe"); // R06
	property p_dclr; in_act |=> !direct; endproperty
	a_dclr: assert property (p_dclr) else $error("direct flag set in active"); // R10
	property p_settle; settling & (settle_cnt < SETTLE_END) |=> !in_act; endproperty
	a_settle: assert property (p_settle) else $error("active before settle"); // R11
	property p_ram; stop_release |=> RAM_VALID_O ##0 FETCH_ZERO_O; endproperty
	a_ram: assert property (p_ram) else $error("release flags wrong"); // R13
	property p_rel; $rose(RAM_VALID_O) |-> $past(in_stop); endproperty
	a_rel: assert property (p_rel) else $error("release outside stop"); // R14
	property p_nop; in_act & instr & nop_cond |=> in_act & INSTR_NOP_O; endproperty
	a_nop: assert property (p_nop) else $error("instruction not cancelled"); // R16
	property p_halt; in_stop & sel1[3] |=> !SUB_OSC_EN_O; endproperty
	a_halt: assert property (p_halt) else $error("32k not halted"); // R17
	property p_div; $changed(div_eff) |-> $past(div_load); endproperty
	a_div: assert property (p_div) else $error("divider changed early"); // R21
	property p_hot; $onehot(mode); endproperty
	a_hot: assert property (p_hot) else $error("mode not one-hot"); // R24

endmodule // lpc_clock_ctrl

// *** pkg/lpc_defs.svh ***
`ifndef LPC_DEFS_SVH
`define LPC_DEFS_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define LPC_ADR_FRAME   6'h0C
`define LPC_ADR_MODE    6'h20
`define LPC_ADR_RAM     6'h21
`define LPC_ADR_SEL1    6'h29
`define LPC_ADR_SEL2    6'h2A
// ----------------------------------------
// field positions
// ----------------------------------------
`define LPC_BIT_LOWSPD  0
`define LPC_BIT_DIRECT  3
`define LPC_BIT_RAMOK   3
`define LPC_BIT_HALT32  3
`define LPC_BIT_SUBDIV  2
// ----------------------------------------
// reset values
// ----------------------------------------
`define LPC_RST_SEL1    4'h0
`define LPC_RST_FREQ    2'h0
`define LPC_RST_FRAME   2'h0
`define LPC_DIV_4       2'h0
`define LPC_DIV_32      2'h3
// ----------------------------------------
// timing counts
// ----------------------------------------
// frame lengths in sub clock ticks
`define LPC_FRAME_T0    10'h008
`define LPC_FRAME_T1    10'h040
`define LPC_FRAME_T2    10'h200
`define LPC_CLK_MHZ     200
`define LPC_SETTLE_US   20
`define LPC_SETTLE_CYC  (`LPC_SETTLE_US * `LPC_CLK_MHZ)
// strap reload span, covers the pin synchroniser
`define LPC_STRAP_CYC   2'h3
`endif

// *** pkg/lpc_pkg.sv ***
package lpc_pkg;
	// operating modes, one-hot
	typedef enum logic [4:0] {
		LPC_ACTIVE  = 5'h01,
		LPC_STANDBY = 5'h02,
		LPC_WATCH   = 5'h04,
		LPC_STOP    = 5'h08,
		LPC_SUBACT  = 5'h10
	} lpc_mode_t;
endpackage

// *** verification/low_power_mode_clock_control_bench.sv ***
module low_power_mode_clock_control_bench;
	timeunit 1ns;
	timeprecision 100ps;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	localparam int SETTLE = 8;   // shortened settle count
	localparam int FRAME  = 64;  // shortest frame in main cycles
	logic       mclk, rst, reset_req, halt_req, wake_req, strap;
	logic       stop_i, sby_i, wos, gie, pend, ovf, wr, rd;
	logic [5:0] addr;
	logic [3:0] wdata, rdata, main_freq, d;
	logic [4:0] mode;
	logic [1:0] core_div;
	wire        rst_pin_n, halt_n, wake_n, sub_clk;
	logic       main_osc, sub_osc, cpu_run, tone, sub_div4;
	logic       strobe, ta_irq, wk_irq, fetch0, nop, ram_ok;
	int         n_errors, total_checks, n;
	// ----------------------------------------
	// instances
	// ----------------------------------------
	lpc_pins_model pins_u (.MCLK_I(mclk), .RESET_REQ_I(reset_req), .HALT_REQ_I(halt_req),
		.WAKE_REQ_I(wake_req), .RESET_PIN_N_O(rst_pin_n), .HALT_RELEASE_N_O(halt_n),
		.WAKE_N_O(wake_n), .SUB_CLK_O(sub_clk));
	lpc_clock_ctrl #(.SETTLE_CYC(SETTLE)) dut_u (.MCLK_I(mclk), .RST_I(rst), .RESET_PIN_N_I(rst_pin_n),
		.HALT_RELEASE_N_I(halt_n), .WAKE_N_I(wake_n), .DIV_STRAP_I(strap), .SUB_CLK_I(sub_clk),
		.STOP_INSTR_I(stop_i), .STANDBY_INSTR_I(sby_i), .WATCH_ON_STOP_I(wos), .GIE_I(gie),
		.IRQ_PEND_I(pend), .TIMERA_OVF_I(ovf), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
		.RDATA_O(rdata), .MODE_O(mode), .MAIN_OSC_EN_O(main_osc), .SUB_OSC_EN_O(sub_osc),
		.CPU_RUN_O(cpu_run), .TONE_EN_O(tone), .CORE_DIV_O(core_div), .MAIN_FREQ_O(main_freq),
		.SUB_DIV4_O(sub_div4), .FRAME_STROBE_O(strobe), .TIMERA_IRQ_O(ta_irq), .WAKE_IRQ_O(wk_irq),
		.FETCH_ZERO_O(fetch0), .INSTR_NOP_O(nop), .RAM_VALID_O(ram_ok));
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	task automatic complete_run();
		if (n_errors == 0 && total_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask
	// wait edges, then let that edge's updates land
	task automatic tick(input int k);
		repeat (k) @(posedge mclk);
		#1;
	endtask
	task automatic wreg(input logic [5:0] a, input logic [3:0] v);
		@(posedge mclk);
		wr <= 1'b1;
		addr <= a;
		wdata <= v;
		@(posedge mclk);
		wr <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rreg(input logic [5:0] a);
		@(posedge mclk);
		rd <= 1'b1;
		addr <= a;
		@(posedge mclk);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask
	task automatic instr(input logic use_sby);
		@(posedge mclk);
		if (use_sby) begin
			sby_i <= 1'b1;
		end else begin
			stop_i <= 1'b1;
		end
		@(posedge mclk);
		stop_i <= 1'b0;
		sby_i <= 1'b0;
		#1;
	endtask
	// bounded wait for a mode, n holds the cycles used
	task automatic wait_mode(input logic [4:0] m, input int bound);
		for (n = 1; n <= bound; n++) begin
			tick(1);
			if (mode === m) begin
				return;
			end
		end
		chk("mode wait", 8'(mode), 8'(m));
		n_errors++;
		complete_run();
	endtask
	// bounded wait for a strobe, n holds the cycles used
	task automatic wait_strobe();
		for (n = 1; n <= 10 * FRAME; n++) begin
			tick(1);
			if (strobe === 1'b1) begin
				return;
			end
		end
		n_errors++;
		complete_run();
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset();
		chk("mode", 8'(mode), 8'(lpc_pkg::LPC_ACTIVE));
		chk("ram valid", 8'(ram_ok), 8'h00);
		chk("core div", 8'(core_div), 8'h00);
		rreg(6'h29);
		chk("sel1 read", 8'(d), 8'h00);
		rreg(6'h3F);
		chk("unmapped read", 8'(d), 8'h00);
	endtask
	task automatic t_regs();
		wreg(6'h29, 4'h4);
		tick(2);
		chk("sub div4", 8'(sub_div4), 8'h01);
		wreg(6'h29, 4'h3);
		wreg(6'h2A, 4'h6);
		tick(2);
		chk("sub div8", 8'(sub_div4), 8'h00);
		chk("freq code", 8'(main_freq), 8'h07);
		chk("div held", 8'(core_div), 8'h00);
		rreg(6'h2A);
		chk("sel2 read", 8'(d), 8'h06);
		wreg(6'h20, 4'h8);
		rreg(6'h20);
		chk("direct in active", 8'(d), 8'h00);
		wait_strobe();
		wreg(6'h0C, 4'h1);
		wait_strobe();
		wait_strobe();
		chk("long frame", 8'(n == 8 * FRAME), 8'h01);
		rreg(6'h0C);
		chk("frame sel read", 8'(d), 8'h01);
		wreg(6'h0C, 4'h0);
	endtask
	task automatic t_nop();
		gie <= 1'b0;
		pend <= 1'b1;
		instr(1'b0);
		chk("nop pulse", 8'(nop), 8'h01);
		tick(2);
		chk("mode kept", 8'(mode), 8'(lpc_pkg::LPC_ACTIVE));
		pend <= 1'b0;
		gie <= 1'b1;
		instr(1'b1);
		chk("standby", 8'(mode), 8'(lpc_pkg::LPC_STANDBY));
		pend <= 1'b1;
		tick(1);
		chk("standby wake", 8'(mode), 8'(lpc_pkg::LPC_ACTIVE));
		pend <= 1'b0;
	endtask
	task automatic t_watch_timer();
		wos <= 1'b1;
		instr(1'b0);
		chk("watch", 8'(mode), 8'(lpc_pkg::LPC_WATCH));
		chk("div taken", 8'(core_div), 8'h02);
		wait_strobe();
		ovf <= 1'b1;
		tick(1);
		ovf <= 1'b0;
		chk("irq early", 8'(ta_irq), 8'h00);
		wait_strobe();
		chk("timer irq", 8'(ta_irq), 8'h01);
		wait_mode(lpc_pkg::LPC_ACTIVE, SETTLE + 20);
		chk("settle", 8'(n > SETTLE), 8'h01);
	endtask
	task automatic t_slow(output int k);
		wreg(6'h20, 4'h1);
		instr(1'b0);
		ovf <= 1'b1;
		tick(1);
		ovf <= 1'b0;
		wait_mode(lpc_pkg::LPC_SUBACT, 3 * FRAME);
		tick(2);
		chk("sub osc main", 8'({main_osc, cpu_run, tone}), 8'h02);
		instr(1'b1);
		chk("sub to watch", 8'(mode), 8'(lpc_pkg::LPC_WATCH));
		wait_strobe();
		wake_req <= 1'b1;
		k = 0;
		while (k < 2) begin
			wait_strobe();
			k++;
			chk("wake irq", 8'(wk_irq), 8'(k == 2));
		end
		tick(1);
		chk("wake to sub", 8'(mode), 8'(lpc_pkg::LPC_SUBACT));
		wreg(6'h20, 4'h8);
		rreg(6'h20);
		chk("direct set", 8'(d), 8'h08);
		instr(1'b0);
		wait_mode(lpc_pkg::LPC_ACTIVE, 2 * FRAME + SETTLE);
		chk("direct time", 8'(n > SETTLE && n < FRAME + SETTLE + 8), 8'h01);
		rreg(6'h20);
		chk("direct cleared", 8'(d), 8'h00);
		wake_req <= 1'b0;
	endtask
	task automatic t_stop();
		wreg(6'h29, 4'hB);
		halt_req <= 1'b1;
		tick(6);
		chk("halt ignored", 8'(mode), 8'(lpc_pkg::LPC_ACTIVE));
		halt_req <= 1'b0;
		wos <= 1'b0;
		tick(4);
		instr(1'b0);
		chk("stop", 8'(mode), 8'(lpc_pkg::LPC_STOP));
		tick(2);
		chk("32k halted", 8'(sub_osc), 8'h00);
		halt_req <= 1'b1;
		wait_mode(lpc_pkg::LPC_ACTIVE, SETTLE + 20);
		chk("fetch zero", 8'(fetch0), 8'h01);
		chk("ram kept", 8'(ram_ok), 8'h01);
		tick(1);
		chk("fetch pulse", 8'(fetch0), 8'h00);
		chk("strap after release", 8'(core_div), 8'h00);
		halt_req <= 1'b0;
	endtask
	task automatic t_pinreset();
		wos <= 1'b1;
		instr(1'b0);
		strap <= 1'b0;
		reset_req <= 1'b1;
		tick(5);
		reset_req <= 1'b0;
		tick(10);
		chk("pin reset mode", 8'(mode), 8'(lpc_pkg::LPC_ACTIVE));
		chk("ram lost", 8'(ram_ok), 8'h00);
		chk("strap div", 8'(core_div), 8'h03);
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		n_errors = 0;
		total_checks = 0;
		{rst, strap, gie} = 3'b111;
		{reset_req, halt_req, wake_req, stop_i, sby_i, wos, pend, ovf, wr, rd} = '0;
		addr = 6'h00;
		wdata = 4'h0;
		repeat (4) @(posedge mclk);
		rst <= 1'b0;
		tick(5);
		t_reset();
		t_regs();
		t_nop();
		t_watch_timer();
		t_slow(n);
		t_stop();
		t_pinreset();
		complete_run();
	end
endmodule // low_power_mode_clock_control_bench

// *** verification/lpc_pins_model.sv ***
module lpc_pins_model #(
	parameter int unsigned HOLD = 160
) (
	// clock
	input  wire logic MCLK_I,
	// bench requests, active high
	input  wire logic RESET_REQ_I,
	input  wire logic HALT_REQ_I,
	input  wire logic WAKE_REQ_I,
	// device pins
	output logic      RESET_PIN_N_O,
	output logic      HALT_RELEASE_N_O,
	output logic      WAKE_N_O,
	output logic      SUB_CLK_O
);
	timeunit 1ns;
	timeprecision 100ps;
	// ----------------------------------------
	// pin drivers
	// ----------------------------------------
	int unsigned hold_cnt;  // cycles the wake level has stood
	logic [1:0]  sub_cnt;   // fast stand-in for the 32k crystal
	initial begin
		hold_cnt = HOLD;
		sub_cnt = 2'h0;
		RESET_PIN_N_O = 1'b1;
		HALT_RELEASE_N_O = 1'b1;
		WAKE_N_O = 1'b1;
		SUB_CLK_O = 1'b0;
	end
	// sub clock runs free: one sub tick every 8 main cycles keeps frames short
	always @(posedge MCLK_I) begin
		sub_cnt <= sub_cnt + 2'h1;
		if (sub_cnt == 2'h3) begin
			SUB_CLK_O <= ~SUB_CLK_O;
		end
		RESET_PIN_N_O <= ~RESET_REQ_I;
		HALT_RELEASE_N_O <= ~HALT_REQ_I;
		if (WAKE_N_O == WAKE_REQ_I && hold_cnt >= HOLD) begin
			WAKE_N_O <= ~WAKE_REQ_I;
			hold_cnt <= 0;
		end else if (hold_cnt < HOLD) begin
			hold_cnt <= hold_cnt + 1;
		end
	end
endmodule // lpc_pins_model
